//--- cesp_map.svh
// Constants of the serial programming port: timing, address layout, sizes.
// Assumes a 200 MHz core clock at both ends; the device samples the link through synchronisers.
// Function
// - SDA falls while SCL high: start
// - SDA rises while SCL high: stop
// - Start returns device to idle state
// - Stop after write starts timed write
// - Lines ignored during internal write cycle
// - Programmer holds select low during write (host only passes select_i through each cycle, no hold)
// - Programmer should poll instead of waiting
// - Device acknowledges bytes by pulling low
// - Each byte followed by ack or stop
// - New owner drives before next rising edge
// - Address bytes shifted MSB first
// - Data bytes shifted LSB first
// - Chip enable unused in programming mode
// - Three address bytes, each acknowledged
// - Unused address bits sent as zero
// - Page index above seven zero bits
// - Pages of 128 bytes, 512/1024 pages
// - Whole read from zero, 65536/131072 bytes
// - Data changes only while clock low
// - Line only pulled low or released
// - Port responds only while select low
`ifndef CESP_MAP_SVH
`define CESP_MAP_SVH
`define CESP_DEV_ADDR 7'h50
`define CESP_ADDR_BYTES 2'h3
`define CESP_PAGE_BYTES 128
`define CESP_PAGE_LSB 7
`define CESP_PAGES_SMALL 512
`define CESP_PAGES_LARGE 1024
`define CESP_TOTAL_BYTES_SMALL 65536
`define CESP_TOTAL_BYTES_LARGE 131072
`define CESP_ADDR_W 17
`define CESP_WRITE_TIME_US 20
`define CESP_LINK_NS 160
`define CESP_CORE_NS 5
`define CESP_HALF_DIV 16
`endif

//--- cesp_pkg.sv
// Types shared by both ends of the serial programming port.
// Assumes the constants header is compiled alongside.
package cesp_pkg;
  typedef enum logic [3:0] {
    CESP_H_IDLE = 4'h1,
    CESP_H_START = 4'h2,
    CESP_H_BITS = 4'h4,
    CESP_H_STOP = 4'h8
  } cesp_host_st_t;
  typedef enum logic [4:0] {
    CESP_D_IDLE = 5'h01,
    CESP_D_DEVADDR = 5'h02,
    CESP_D_ADDR = 5'h04,
    CESP_D_WDATA = 5'h08,
    CESP_D_RDATA = 5'h10
  } cesp_dev_st_t;
endpackage

//--- cesp_link_if.sv
// Two-wire programming link joining programmer and memory.
// Open-drain data line is resolved by the bench from both enables.
`timescale 1ns/1ps
`default_nettype none
interface cesp_link_if;
  logic prog_serial_clock;
  logic sda_line;
  logic host_sda_oe_n;
  logic dev_sda_oe_n;
  logic programming_select_n;
  modport host (output prog_serial_clock, output host_sda_oe_n, output programming_select_n, input sda_line);
  modport dev (input prog_serial_clock, output dev_sda_oe_n, input programming_select_n, input sda_line);
endinterface
`default_nettype wire

//--- cesp_edge_det.sv
// Start and stop detector for the serial data line, run on a sampling clock.
// Inputs must already be synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module cesp_edge_det (
  input wire logic clk_i,     // Sampling clock
  input wire logic reset_n_i, // Async reset
  input wire logic en_i,      // Clock enable
  input wire logic scl_i,     // Synced clock line
  input wire logic sda_i,     // Synced data line
  output logic start_o,       // Start pulse
  output logic stop_o         // Stop pulse
);
  logic sda_ff;
  logic scl_ff;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sda_ff <= 1'h1;
      scl_ff <= 1'h1;
    end
    else if (en_i)
    begin
      sda_ff <= sda_i;
      scl_ff <= scl_i;
    end
  end
  assign start_o = en_i && scl_ff && scl_i && sda_ff && !sda_i;
  assign stop_o = en_i && scl_ff && scl_i && !sda_ff && sda_i;
endmodule
`default_nettype wire

//--- cesp_dev.sv
// Memory end of the programming port; logic runs on the core clock, sampling
// the link clock and data through two-flop synchronisers.
// Memory array is a local array; timed write runs from the stop.
`timescale 1ns/1ps
`default_nettype none
`include "cesp_map.svh"
module cesp_dev #(
  parameter int ADDR_W = `CESP_ADDR_W,
  parameter int WR_CYC = (`CESP_WRITE_TIME_US * 1000) / `CESP_CORE_NS
) (
  input wire logic core_clk_i,   // Core clock
  input wire logic reset_n_i,    // Async reset
  input wire logic clk_en_i,     // Clock enable
  input wire logic chip_enable_n_i, // Unused in programming mode
  cesp_link_if.dev link,          // Serial link
  output logic busy_o,           // Internal write cycle
  output logic [7:0] last_byte_o // Last data byte written
);
  import cesp_pkg::*;
  logic [1:0] scl_sy_ff, sda_sy_ff, sel_sy_ff;
  logic start_w, stop_w, scl_rise, scl_fall, scl_d_ff;
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  cesp_dev_st_t st_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic [1:0] abyte_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic wrote_ff, ack_ff, oe_n_ff, rd_ff;
  logic [31:0] wcnt_ff;
  // chip enable plays no part here
  wire active = clk_en_i && !sel_sy_ff[1];
  wire busy = wcnt_ff != 32'h0;
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      scl_sy_ff <= 2'h3;
      sda_sy_ff <= 2'h3;
      sel_sy_ff <= 2'h3;
      scl_d_ff <= 1'h1;
    end
    else if (clk_en_i)
    begin
      scl_sy_ff <= {scl_sy_ff[0], link.prog_serial_clock};
      sda_sy_ff <= {sda_sy_ff[0], link.sda_line};
      sel_sy_ff <= {sel_sy_ff[0], link.programming_select_n};
      scl_d_ff <= scl_sy_ff[1];
    end
  end
  assign scl_rise = scl_sy_ff[1] && !scl_d_ff;
  assign scl_fall = !scl_sy_ff[1] && scl_d_ff;
  cesp_edge_det u_edge (
    .clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .en_i(active && !busy),
    .scl_i(scl_sy_ff[1]),
    .sda_i(sda_sy_ff[1]),
    .start_o(start_w),
    .stop_o(stop_w)
  );
  wire [7:0] rd_byte = mem[addr_ff];
  // Byte is complete once the eighth clock falls
  wire at_ack = scl_fall && !ack_ff && bit_ff == 4'h8;
  wire mem_we = active && !busy && st_ff == CESP_D_WDATA && at_ack;
  always_ff @(posedge core_clk_i)
  begin
    // byte stored before the timed cycle
    if (mem_we)
      mem[addr_ff] <= sh_ff;
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_ff <= CESP_D_IDLE;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      abyte_ff <= 2'h0;
      addr_ff <= '0;
      wrote_ff <= 1'h0;
      ack_ff <= 1'h0;
      oe_n_ff <= 1'h1;
      rd_ff <= 1'h0;
      wcnt_ff <= 32'h0;
      last_byte_o <= 8'h00;
      busy_o <= 1'h0;
    end
    else if (clk_en_i)
    begin
      if (busy)
      begin
        wcnt_ff <= wcnt_ff - 32'h1;
        busy_o <= wcnt_ff != 32'h1;
      end
      else if (!active)
      begin
        st_ff <= CESP_D_IDLE;
        oe_n_ff <= 1'h1;
      end
      else if (start_w)
      begin
        st_ff <= CESP_D_DEVADDR;
        bit_ff <= 4'h0;
        ack_ff <= 1'h0;
        wrote_ff <= 1'h0;
        oe_n_ff <= 1'h1;
      end
      else if (stop_w)
      begin
        st_ff <= CESP_D_IDLE;
        oe_n_ff <= 1'h1;
        if (wrote_ff)
        begin
          wcnt_ff <= WR_CYC[31:0];
          busy_o <= WR_CYC != 0;
        end
        wrote_ff <= 1'h0;
      end
      else if (st_ff != CESP_D_IDLE && scl_rise)
      begin
        if (ack_ff)
        begin
          if (rd_ff && sda_sy_ff[1])
            st_ff <= CESP_D_IDLE;
        end
        else if (st_ff == CESP_D_WDATA)
          sh_ff <= {sda_sy_ff[1], sh_ff[7:1]};
        else if (st_ff != CESP_D_RDATA)
          sh_ff <= {sh_ff[6:0], sda_sy_ff[1]};
        if (!ack_ff)
          bit_ff <= bit_ff + 4'h1;
      end
      else if (st_ff != CESP_D_IDLE && scl_fall)
      begin
        if (ack_ff)
        begin
          ack_ff <= 1'h0;
          bit_ff <= 4'h0;
          oe_n_ff <= 1'h1;
          if (st_ff == CESP_D_RDATA)
            oe_n_ff <= rd_byte[0];
        end
        // every byte gets an ack slot
        else if (bit_ff == 4'h8)
        begin
          ack_ff <= 1'h1;
          oe_n_ff <= 1'h0;
          case (st_ff)
            CESP_D_DEVADDR:
            begin
              if (sh_ff[7:1] != `CESP_DEV_ADDR)
              begin
                st_ff <= CESP_D_IDLE;
                oe_n_ff <= 1'h1;
              end
              else if (sh_ff[0])
              begin
                st_ff <= CESP_D_RDATA;
                rd_ff <= 1'h1;
              end
              else
              begin
                st_ff <= CESP_D_ADDR;
                rd_ff <= 1'h0;
                abyte_ff <= 2'h0;
              end
            end
            CESP_D_ADDR:
            begin
              addr_ff <= ADDR_W'({addr_ff, sh_ff});
              abyte_ff <= abyte_ff + 2'h1;
              if (abyte_ff == `CESP_ADDR_BYTES - 2'h1)
                st_ff <= CESP_D_WDATA;
            end
            CESP_D_WDATA:
            begin
              wrote_ff <= 1'h1;
              last_byte_o <= sh_ff;
              addr_ff <= {addr_ff[ADDR_W-1:`CESP_PAGE_LSB], addr_ff[`CESP_PAGE_LSB-1:0] + 7'h1};
            end
            CESP_D_RDATA:
            begin
              oe_n_ff <= 1'h1;
              addr_ff <= addr_ff + 1'b1;
            end
            default:
              st_ff <= CESP_D_IDLE;
          endcase
        end
        else if (st_ff == CESP_D_RDATA)
          oe_n_ff <= rd_byte[bit_ff[2:0]];
      end
    end
  end
  assign link.dev_sda_oe_n = oe_n_ff;
endmodule
`default_nettype wire

//--- cesp_host.sv
// Programmer end: divides the core clock into the serial clock and shifts
// single bytes on command; user sequences start, byte, stop.
`timescale 1ns/1ps
`default_nettype none
`include "cesp_map.svh"
module cesp_host #(
  parameter int HALF_DIV = `CESP_HALF_DIV
) (
  input wire logic core_clk_i,     // Core clock
  input wire logic reset_n_i,      // Async reset
  input wire logic clk_en_i,       // Clock enable
  input wire logic select_i,       // Enter programming mode
  input wire logic cmd_valid_i,    // Command strobe
  input wire logic [1:0] cmd_i,    // 0 start,1 byte,2 stop
  input wire logic [7:0] wdata_i,  // Byte to send
  input wire logic lsb_first_i,    // Data byte order
  input wire logic ack_out_i,      // Ack to give on read
  input wire logic read_i,         // Byte is read from device
  cesp_link_if.host link,          // Serial link
  output logic ready_o,            // Idle, accepts command
  output logic done_o,             // Command finished pulse
  output logic [7:0] rdata_o,      // Received byte
  output logic ack_o               // Ack seen (low line)
);
  import cesp_pkg::*;
  cesp_host_st_t st_ff;
  logic [7:0] div_ff;
  logic [1:0] ph_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic lsb_ff, rd_ff, ackg_ff, scl_ff, oe_n_ff, sel_ff;
  logic [1:0] sda_sy_ff;
  wire tick = div_ff == 8'(HALF_DIV - 1);
  wire [7:0] idx = lsb_ff ? {4'h0, bit_ff} : 8'(4'h7 - bit_ff);
  wire tx_bit = bit_ff == 4'h8 ? !(rd_ff && ackg_ff) : (rd_ff ? 1'h1 : sh_ff[idx[2:0]]);
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      st_ff <= CESP_H_IDLE;
      div_ff <= 8'h00;
      ph_ff <= 2'h0;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      lsb_ff <= 1'h0;
      rd_ff <= 1'h0;
      ackg_ff <= 1'h0;
      scl_ff <= 1'h1;
      oe_n_ff <= 1'h1;
      sel_ff <= 1'h1;
      sda_sy_ff <= 2'h3;
      ready_o <= 1'h1;
      done_o <= 1'h0;
      rdata_o <= 8'h00;
      ack_o <= 1'h0;
    end
    else if (clk_en_i)
    begin
      sda_sy_ff <= {sda_sy_ff[0], link.sda_line};
      // select follows caller each cycle, write cycle included
      sel_ff <= !select_i;
      done_o <= 1'h0;
      div_ff <= tick ? 8'h00 : div_ff + 8'h01;
      case (st_ff)
        CESP_H_IDLE:
          if (cmd_valid_i)
          begin
            ready_o <= 1'h0;
            ph_ff <= 2'h0;
            bit_ff <= 4'h0;
            sh_ff <= wdata_i;
            lsb_ff <= lsb_first_i; // byte order per kind
            rd_ff <= read_i;
            ackg_ff <= ack_out_i;
            st_ff <= cmd_i == 2'h0 ? CESP_H_START : (cmd_i == 2'h1 ? CESP_H_BITS : CESP_H_STOP);
          end
        CESP_H_START:
          if (tick)
          begin
            ph_ff <= ph_ff + 2'h1;
            case (ph_ff)
              2'h0: oe_n_ff <= 1'h1;
              2'h1: scl_ff <= 1'h1;
              2'h2: oe_n_ff <= 1'h0;
              default:
              begin
                scl_ff <= 1'h0;
                st_ff <= CESP_H_IDLE;
                ready_o <= 1'h1;
                done_o <= 1'h1;
              end
            endcase
          end
        CESP_H_BITS:
          if (tick)
          begin
            ph_ff <= ph_ff + 2'h1;
            case (ph_ff)
              2'h0: oe_n_ff <= tx_bit; // release for high
              2'h1: scl_ff <= 1'h1;
              2'h2:
              begin
                if (bit_ff == 4'h8)
                  ack_o <= !sda_sy_ff[1];
                else if (lsb_ff)
                  rdata_o <= {sda_sy_ff[1], rdata_o[7:1]};
                else
                  rdata_o <= {rdata_o[6:0], sda_sy_ff[1]};
              end
              default:
              begin
                scl_ff <= 1'h0;
                bit_ff <= bit_ff + 4'h1;
                if (bit_ff == 4'h8)
                begin
                  oe_n_ff <= 1'h1;
                  st_ff <= CESP_H_IDLE;
                  ready_o <= 1'h1;
                  done_o <= 1'h1;
                end
              end
            endcase
          end
        CESP_H_STOP:
          if (tick)
          begin
            ph_ff <= ph_ff + 2'h1;
            case (ph_ff)
              2'h0: oe_n_ff <= 1'h0;
              2'h1: scl_ff <= 1'h1;
              2'h2: oe_n_ff <= 1'h1;
              default:
              begin
                st_ff <= CESP_H_IDLE;
                ready_o <= 1'h1;
                done_o <= 1'h1;
              end
            endcase
          end
        default:
          st_ff <= CESP_H_IDLE;
      endcase
    end
  end
  assign link.prog_serial_clock = scl_ff;
  assign link.host_sda_oe_n = oe_n_ff;
  assign link.programming_select_n = sel_ff;
endmodule
`default_nettype wire

//--- cesp_link_asserts.sv
// Protocol checker for the two-wire programming link.
// Sees only the link wires plus the programmer's core clock and reset.
`timescale 1ns/1ps
`default_nettype none
module cesp_link_asserts (
  input wire logic core_clk_i,          // Core clock
  input wire logic reset_n_i,           // Async reset
  input wire logic prog_serial_clock,   // Serial clock
  input wire logic sda_line,            // Resolved data wire
  input wire logic host_sda_oe_n,       // Programmer pull-down
  input wire logic dev_sda_oe_n,        // Memory pull-down
  input wire logic programming_select_n // Select, active low
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence start_seq;
    prog_serial_clock && $fell(sda_line);
  endsequence
  sequence stop_seq;
    prog_serial_clock && $rose(sda_line);
  endsequence
  a_start_goes_idle: assert property (start_seq |=> dev_sda_oe_n [*8])
    else $error("memory drives data right after start");
  a_stop_ignores_bus: assert property (stop_seq |=> dev_sda_oe_n [*8])
    else $error("memory drives data right after stop");
  a_stop_keeps_select: assert property (stop_seq |-> !programming_select_n [*8])
    else $error("select released during write cycle");
  a_dev_change_low: assert property ($changed(dev_sda_oe_n) |-> !prog_serial_clock)
    else $error("memory data changed while clock high");
  a_dev_stable_high: assert property (prog_serial_clock && $past(prog_serial_clock) |-> $stable(dev_sda_oe_n))
    else $error("memory data unstable in clock high time");
  a_drive_needs_select: assert property (!dev_sda_oe_n |-> !programming_select_n && !$past(programming_select_n, 2))
    else $error("memory drives data while not selected");
  a_dev_release_bound: assert property ($fell(dev_sda_oe_n) |-> ##[1:200] dev_sda_oe_n)
    else $error("memory holds data line too long");
  a_scl_high_hold: assert property ($rose(prog_serial_clock) |-> prog_serial_clock [*4])
    else $error("serial clock high time too short");
endmodule
`default_nettype wire

//--- config_eeprom_serial_prog_port_test.sv
// Self-checking bench: programmer and memory ends joined over the link.
// Drives the programmer command side and resolves the open-drain data wire.
`timescale 1ns/1ps
`default_nettype none
`include "cesp_map.svh"
module config_eeprom_serial_prog_port_test;
  localparam int WR = 400;
  localparam logic [7:0] DEVW = {`CESP_DEV_ADDR, 1'b0};
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [1:0] cmd_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic lsb_first_i = 1'b0;
  logic ack_out_i = 1'b0;
  logic read_i = 1'b0;
  logic ce_n = 1'b1;
  logic sel = 1'b1;
  logic ready_o, done_o, ack_o, busy_o;
  logic [7:0] rdata_o, last_byte_o;
  logic [9:0] note_q[$];
  logic [9:0] nt;
  logic [31:0] seed = 32'h0000590E;
  logic [7:0] d [3];
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  cesp_link_if u_cesp_link_if ();
  // Open-drain wire with pull-up
  assign u_cesp_link_if.sda_line = u_cesp_link_if.host_sda_oe_n & u_cesp_link_if.dev_sda_oe_n;
  cesp_host #(.HALF_DIV(4)) u_cesp_host (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
    .select_i(sel), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .wdata_i(wdata_i), .lsb_first_i(lsb_first_i),
    .ack_out_i(ack_out_i), .read_i(read_i), .link(u_cesp_link_if.host), .ready_o(ready_o), .done_o(done_o),
    .rdata_o(rdata_o), .ack_o(ack_o));
  cesp_dev #(.ADDR_W(10), .WR_CYC(WR)) u_cesp_dev (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(1'b1), .chip_enable_n_i(ce_n), .link(u_cesp_link_if.dev), .busy_o(busy_o), .last_byte_o(last_byte_o));
  cesp_link_asserts u_cesp_link_asserts (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
    .prog_serial_clock(u_cesp_link_if.prog_serial_clock), .sda_line(u_cesp_link_if.sda_line),
    .host_sda_oe_n(u_cesp_link_if.host_sda_oe_n), .dev_sda_oe_n(u_cesp_link_if.dev_sda_oe_n),
    .programming_select_n(u_cesp_link_if.programming_select_n));
  initial
  begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One command: note the expected result, hand over, wait for completion
  task automatic op(input logic [1:0] c, input logic [7:0] x, input logic lsb, input logic rd, input logic ao,
                    input logic [9:0] ne);
    note_q.push_back(ne);
    seed = xs(seed);
    while (ready_o !== 1'b1)
      @(negedge core_clk_i);
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    wdata_i <= x;
    lsb_first_i <= lsb;
    read_i <= rd;
    ack_out_i <= ao;
    ce_n <= seed[0];
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b0;
    for (int n = 0; n < 400 && done_o !== 1'b1; n++)
      @(negedge core_clk_i);
    if (done_o !== 1'b1)
    begin
      miscompares++;
      $display("unexpected command done expected 1 seen 0");
    end
  endtask
  task automatic st();
    op(2'h0, 8'hFF, 1'b0, 1'b0, 1'b0, 10'h000);
  endtask
  task automatic sp();
    op(2'h2, 8'hFF, 1'b0, 1'b0, 1'b0, 10'h000);
  endtask
  task automatic wb(input logic [7:0] x, input logic lsb, input logic a);
    op(2'h1, x, lsb, 1'b0, 1'b0, {2'h1, 7'h00, a});
  endtask
  task automatic rb(input logic [7:0] e, input logic ao);
    op(2'h1, 8'hFF, 1'b1, 1'b1, ao, {2'h2, e});
  endtask
  task automatic rdseq(input logic [16:0] a, input int n, input int k);
    st();
    wb(DEVW, 1'b0, 1'b1);
    wb({7'h00, a[16]}, 1'b0, 1'b1);
    wb(a[15:8], 1'b0, 1'b1);
    wb(a[7:0], 1'b0, 1'b1);
    st();
    wb(DEVW | 8'h01, 1'b0, 1'b1);
    for (int i = 0; i < n; i++)
      rb(d[k + i], i < n - 1);
    sp();
  endtask
  // Result watcher
  always @(negedge core_clk_i)
  begin
    if (done_o === 1'b1 && note_q.size() > 0)
    begin
      nt = note_q.pop_front();
      if (nt[9:8] == 2'h1)
        check("ack", {7'h00, ack_o}, nt[7:0]);
      if (nt[9:8] == 2'h2)
        check("read data", rdata_o, nt[7:0]);
    end
  end
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      miscompares++;
      end_sim();
    end
  end
  initial
  begin
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      seed = xs(seed);
      d[i] = seed[15:8];
    end
    st();
    wb(DEVW, 1'b0, 1'b1);
    wb(8'h00, 1'b0, 1'b1);
    st();
    wb(DEVW, 1'b0, 1'b1);
    wb(8'h00, 1'b0, 1'b1);
    wb(8'h01, 1'b0, 1'b1);
    wb(8'hFE, 1'b0, 1'b1);
    for (int i = 0; i < 3; i++)
      wb(d[i], 1'b1, 1'b1);
    sp();
    check("busy after stop", {7'h00, busy_o}, 8'h01);
    $display("test page write done");
    st();
    wb(DEVW, 1'b0, 1'b0);
    // poll rather than a fixed wait
    for (int n = 0; n < WR && busy_o === 1'b1; n++)
      @(negedge core_clk_i);
    check("busy end", {7'h00, busy_o}, 8'h00);
    check("last byte", last_byte_o, d[2]);
    $display("test write poll done");
    st();
    wb(DEVW ^ 8'h04, 1'b0, 1'b0);
    sp();
    check("busy after refused", {7'h00, busy_o}, 8'h00);
    $display("test wrong address done");
    // Deselected port must not answer
    @(posedge core_clk_i);
    sel <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    st();
    wb(DEVW, 1'b0, 1'b0);
    @(posedge core_clk_i);
    sel <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    $display("test deselect done");
    rdseq(17'h001FE, 2, 0);
    rdseq(17'h00180, 1, 2);
    $display("test readback done");
    @(negedge core_clk_i);
    end_sim();
  end
endmodule
`default_nettype wire
